// file: pic_field.sv
// field model: sensor, remote source and current sensors
`default_nettype none
module pic_field (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic signed [15:0] pv_set,
  input wire logic signed [15:0] rs_set,
  input wire logic [15:0] ct_set,
  output logic signed [15:0] measured_value,
  output logic signed [15:0] remote_setpoint,
  output logic [15:0] current_sensor_input_one,
  output logic [15:0] current_sensor_input_two
);
  // both current sensors watch the same load
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      measured_value <= 16'h0000;
      remote_setpoint <= 16'h0000;
      current_sensor_input_one <= 16'h0000;
      current_sensor_input_two <= 16'h0000;
    end else begin
      measured_value <= pv_set;
      remote_setpoint <= rs_set;
      current_sensor_input_one <= ct_set;
      current_sensor_input_two <= ct_set;
    end
  end
endmodule : pic_field
`default_nettype wire

// file: pic_lag.sv
// first-order lag filter stepped once per sample
`default_nettype none
module pic_lag #(
  parameter int W = 16,
  parameter int TW = 10
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic step,
  input wire logic [TW-1:0] tau,
  input wire logic signed [W-1:0] din,
  output logic signed [W-1:0] dout
);
  localparam int AW = W + 16;
  logic signed [AW-1:0] acc_r;
  logic signed [AW:0] diff;
  logic signed [AW:0] den;
  logic signed [AW:0] quo;
  // gain is sample / (tau + sample), tau counted in samples
  assign diff = $signed({din[W-1], din, 16'h0000}) - (AW+1)'(acc_r);
  assign den = $signed({{(AW+1-TW){1'b0}}, tau}) + (AW+1)'(1);
  assign quo = diff / den;
  assign dout = acc_r[AW-1:16];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_r <= '0;
    end else if (step) begin
      if (tau == '0) begin
        acc_r <= {din, 16'h0000};
      end else begin
        acc_r <= acc_r + quo[AW-1:0];
      end
    end
  end
endmodule : pic_lag
`default_nettype wire

// file: pic_pkg.sv
// constants for the process input conditioning block
`default_nettype none
package pic_pkg;
  // clock and time base
  localparam int CLK_HZ = 25_000_000;
  localparam int MS_TICK_US = 1000;
  localparam int MS_TICK_CYCLES = CLK_HZ / 1_000_000 * MS_TICK_US;
  localparam int SAMPLE_MS = 100;
  localparam int INPUT_SPAN = 10000;
  localparam int ADDR_W = 7;
  // register byte offsets
  localparam logic [6:0] OFF_CTRL = 7'h00;
  localparam logic [6:0] OFF_PV_BIAS = 7'h04;
  localparam logic [6:0] OFF_PV_FILT = 7'h08;
  localparam logic [6:0] OFF_PV_RATIO = 7'h0C;
  localparam logic [6:0] OFF_PV_CUT = 7'h10;
  localparam logic [6:0] OFF_RS_BIAS = 7'h14;
  localparam logic [6:0] OFF_RS_FILT = 7'h18;
  localparam logic [6:0] OFF_RS_RATIO = 7'h1C;
  localparam logic [6:0] OFF_HEAT_CYC = 7'h20;
  localparam logic [6:0] OFF_COOL_CYC = 7'h24;
  localparam logic [6:0] OFF_BRK1 = 7'h28;
  localparam logic [6:0] OFF_BRK2 = 7'h2C;
  localparam logic [6:0] OFF_MLT1 = 7'h30;
  localparam logic [6:0] OFF_MLT2 = 7'h34;
  localparam logic [6:0] OFF_HSV1 = 7'h38;
  localparam logic [6:0] OFF_HSV2 = 7'h3C;
  localparam logic [6:0] OFF_DELAY = 7'h40;
  localparam logic [6:0] OFF_STATUS = 7'h44;
  localparam logic [6:0] OFF_MASK = 7'h48;
  localparam logic [6:0] OFF_PV_OUT = 7'h4C;
  localparam logic [6:0] OFF_RS_OUT = 7'h50;
  localparam logic [6:0] OFF_PV_CTRL = 7'h54;
  localparam int NCFG = 17;
  // control register fields
  localparam int CB_SQRT = 0;
  localparam int CB_HF1_B = 1;
  localparam int CB_HF2_B = 2;
  localparam int CB_HEAT_RELAY = 3;
  localparam int CB_HEAT_CONT = 4;
  localparam int CB_COOL_RELAY = 5;
  localparam int CB_COOL_CONT = 6;
  localparam int CB_HEATCOOL = 7;
  // status fields
  localparam int ST_BRK1 = 0;
  localparam int ST_BRK2 = 1;
  localparam int ST_MLT1 = 2;
  localparam int ST_MLT2 = 3;
  // cycle time defaults in tenths of a second
  localparam logic [9:0] CYC_RELAY_DEF = 10'h0C8;
  localparam logic [9:0] CYC_PULSE_DEF = 10'h014;
  // reset values and ranges, indexed by offset / 4
  localparam logic [15:0] CFG_RST [NCFG] = '{
    16'h0028, 16'h0000, 16'h0000, 16'h03E8, 16'h0000, 16'h0000,
    16'h0000, 16'h03E8, 16'h0000, 16'h0000, 16'h012C, 16'h012C,
    16'h012C, 16'h012C, 16'h0000, 16'h0000, 16'h0505};
  localparam int CFG_LO [NCFG] = '{0, -INPUT_SPAN, 0, 500, 0, -INPUT_SPAN,
    0, 1, 0, 0, 0, 0, 0, 0, 0, 0, 0};
  localparam int CFG_HI [NCFG] = '{255, INPUT_SPAN, 1000, 1500, 2500,
    INPUT_SPAN, 1000, 9999, 1000, 1000, 1000, 1000, 1000, 1000, 65535,
    65535, 65535};
  localparam logic [NCFG-1:0] CFG_SGN = 17'h00022;
  localparam logic [3:0] MASK_RST = 4'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : pic_pkg
`default_nettype wire

// file: pic_top.sv
// process input conditioning, heater fault check and cycle outputs
`default_nettype none
// Behaviour
// RL1: two break thresholds, 0.1-100.0 % of set value, default 30.0, 0 is off
// RL2: two melt thresholds, 0.1-100.0 % of set value, default 30.0, 0 is off
// RL3: thresholds act only when that channel is in continuous type B mode
// RL4: low point sv*mv - brk*sv; alarm after delay samples at or below
// RL5: high point sv*mv + melt*sv; alarm after delay samples at or above
// RL6: signed measured bias within plus or minus span, default 0
// RL7: measured lag filter 0.1-100.0 s, off bypasses
// RL8: measured ratio 0.500-1.500, default 1.000
// RL9: with square root on, values below cut-off 0-25.00 % read as zero
// RL10: signed remote bias within plus or minus span, default 0
// RL11: remote lag filter 0.1-100.0 s, off bypasses
// RL12: remote ratio 0.001-9.999, default 1.000
// RL13: cascade or ratio setting reuses the remote bias, filter and ratio
// RL14: heat cycle 0.1-100.0 s, default 20.0 relay or 2.0 pulse
// RL15: cool side has its own cycle time in heat/cool mode
// RL16: no cycle timing for continuous outputs
// RL17: output on for output fraction times cycle, off the rest
module pic_top
  import pic_pkg::*;
#(
  parameter int MS_CYCLES = pic_pkg::MS_TICK_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [pic_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [pic_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic signed [15:0] measured_value,
  input wire logic signed [15:0] remote_setpoint,
  input wire logic [15:0] current_sensor_input_one,
  input wire logic [15:0] current_sensor_input_two,
  input wire logic [9:0] manipulated_output_one,
  input wire logic [9:0] manipulated_output_two,
  output logic signed [15:0] pv_out,
  output logic signed [15:0] rs_out,
  output logic signed [15:0] pv_ctrl_out,
  output logic heat_output,
  output logic cool_output,
  output logic heater_fault_alarm_one,
  output logic heater_fault_alarm_two,
  output logic irq
);
  import pic_pkg::*;

  function automatic logic [15:0] fit(input logic [4:0] ix,
                                      input logic [15:0] v);
    int s;
    s = CFG_SGN[ix] ? int'($signed(v)) : int'({16'h0000, v});
    if (s < CFG_LO[ix]) s = CFG_LO[ix];
    if (s > CFG_HI[ix]) s = CFG_HI[ix];
    return s[15:0];
  endfunction : fit

  function automatic logic signed [15:0] sat16(input logic signed [31:0] v);
    if (v > 32'sd32767) return 16'sh7FFF;
    if (v < -32'sd32768) return 16'sh8000;
    return v[15:0];
  endfunction : sat16

  // ratio in thousandths, then bias
  function automatic logic signed [15:0] scale(input logic signed [15:0] x,
                                               input logic [15:0] ratio,
                                               input logic [15:0] bias);
    logic signed [31:0] p;
    p = 32'(x) * $signed({16'h0000, ratio});
    return sat16(p / 32'sd1000 + 32'($signed(bias)));
  endfunction : scale

  // ct*1000 against sv*(mv -/+ th), all fractions in tenths of a percent
  function automatic logic [1:0] hb_cmp(input logic [15:0] ct,
                                        input logic [15:0] sv,
                                        input logic [9:0] mv,
                                        input logic [15:0] brk,
                                        input logic [15:0] mlt);
    logic signed [31:0] lhs;
    logic signed [31:0] lo;
    logic signed [31:0] hi;
    lhs = $signed({16'h0000, ct}) * 32'sd1000;
    lo = $signed({16'h0000, sv}) * ($signed({22'h0, mv}) - 32'($signed(brk)));
    hi = $signed({16'h0000, sv}) * ($signed({22'h0, mv}) + 32'($signed(mlt)));
    return {mlt != 16'h0 && lhs >= hi, brk != 16'h0 && lhs <= lo};
  endfunction : hb_cmp

  logic [15:0] cfg_r [NCFG];
  logic [3:0] mask_r;
  logic [3:0] sts_r;
  logic aw_have_r;
  logic w_have_r;
  logic [4:0] aw_ix_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic [$clog2(MS_CYCLES)-1:0] div_r;
  logic [6:0] ms_cnt_r;
  logic ms_tick_r;
  logic smp_r;
  logic smp_d_r;
  logic signed [15:0] pv_pre_r;
  logic signed [15:0] rs_pre_r;
  logic signed [15:0] pv_ctrl_r;
  logic [7:0] cnt_lo_r [2];
  logic [7:0] cnt_hi_r [2];

  // bus decode
  wire do_wr = aw_have_r && w_have_r && !bvalid_r;
  wire wr_map = aw_ix_r < 5'(NCFG) || aw_ix_r == OFF_MASK[6:2];
  wire [15:0] wr_old = aw_ix_r < 5'(NCFG) ? cfg_r[aw_ix_r] : {12'h0, mask_r};
  wire [15:0] wr_val = {w_strb_r[1] ? w_data_r[15:8] : wr_old[15:8],
                        w_strb_r[0] ? w_data_r[7:0] : wr_old[7:0]};
  wire ar_take = s_axi_arvalid && !rvalid_r;
  wire [4:0] ar_ix = s_axi_araddr[6:2];
  wire rd_sts = ar_take && ar_ix == OFF_STATUS[6:2];
  wire signed [15:0] pv_f;
  wire signed [15:0] rs_f;
  logic [31:0] rd_word;
  logic rd_map;
  always_comb begin
    rd_map = 1'b1;
    rd_word = 32'h0000_0000;
    if (ar_ix < 5'(NCFG)) begin
      rd_word = {16'h0000, cfg_r[ar_ix]};
    end else if (ar_ix == OFF_STATUS[6:2]) begin
      rd_word = {28'h0, sts_r};
    end else if (ar_ix == OFF_MASK[6:2]) begin
      rd_word = {28'h0, mask_r};
    end else if (ar_ix == OFF_PV_OUT[6:2]) begin
      rd_word = 32'(pv_f);
    end else if (ar_ix == OFF_RS_OUT[6:2]) begin
      rd_word = 32'(rs_f);
    end else if (ar_ix == OFF_PV_CTRL[6:2]) begin
      rd_word = 32'(pv_ctrl_r);
    end else begin
      rd_map = 1'b0;
    end
  end

  assign s_axi_awready = !aw_have_r;
  assign s_axi_wready = !w_have_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // named views of the configuration
  wire [15:0] ctrl = cfg_r[OFF_CTRL[6:2]];
  wire [15:0] dly = cfg_r[OFF_DELAY[6:2]];
  wire [1:0] type_b = {ctrl[CB_HF2_B], ctrl[CB_HF1_B]};
  wire [15:0] hsv [2] = '{cfg_r[OFF_HSV1[6:2]], cfg_r[OFF_HSV2[6:2]]};
  wire [15:0] brk [2] = '{cfg_r[OFF_BRK1[6:2]], cfg_r[OFF_BRK2[6:2]]};
  wire [15:0] mlt [2] = '{cfg_r[OFF_MLT1[6:2]], cfg_r[OFF_MLT2[6:2]]};
  wire [15:0] ct [2] = '{current_sensor_input_one, current_sensor_input_two};
  wire [9:0] mv [2] = '{manipulated_output_one, manipulated_output_two};
  wire [7:0] dlim [2] = '{dly[7:0] == 8'h0 ? 8'h01 : dly[7:0],
                          dly[15:8] == 8'h0 ? 8'h01 : dly[15:8]};
  wire [1:0] hb0 = hb_cmp(ct[0], hsv[0], mv[0], brk[0], mlt[0]); // [RL4] [RL5]
  wire [1:0] hb1 = hb_cmp(ct[1], hsv[1], mv[1], brk[1], mlt[1]); // [RL4] [RL5]
  wire [1:0] lo_hit = {hb1[0], hb0[0]};
  wire [1:0] hi_hit = {hb1[1], hb0[1]};
  wire [1:0] lo_al = {cnt_lo_r[1] >= dlim[1], cnt_lo_r[0] >= dlim[0]};
  wire [1:0] hi_al = {cnt_hi_r[1] >= dlim[1], cnt_hi_r[0] >= dlim[0]};
  wire [3:0] sts_set = {hi_al, lo_al};

  // cut-off level in input units from hundredths of a percent of span
  wire signed [31:0] cut_lvl =
    $signed({16'h0000, cfg_r[OFF_PV_CUT[6:2]]}) * 32'(INPUT_SPAN) / 32'sd10000;
  // zero means use the default that suits the output type
  wire [9:0] heat_cyc = cfg_r[OFF_HEAT_CYC[6:2]][9:0] != 10'h0 ?
    cfg_r[OFF_HEAT_CYC[6:2]][9:0] :
    (ctrl[CB_HEAT_RELAY] ? CYC_RELAY_DEF : CYC_PULSE_DEF); // [RL14]
  wire [9:0] cool_cyc = cfg_r[OFF_COOL_CYC[6:2]][9:0] != 10'h0 ?
    cfg_r[OFF_COOL_CYC[6:2]][9:0] :
    (ctrl[CB_COOL_RELAY] ? CYC_RELAY_DEF : CYC_PULSE_DEF); // [RL15]

  // register writes, clamped into legal range
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < NCFG; i++) begin
        cfg_r[i] <= CFG_RST[i];
      end
      mask_r <= MASK_RST;
    end else if (do_wr) begin
      if (aw_ix_r < 5'(NCFG)) begin
        cfg_r[aw_ix_r] <= fit(aw_ix_r, wr_val); // [RL1] [RL2] [RL6] [RL8]
      end else if (aw_ix_r == OFF_MASK[6:2]) begin
        mask_r <= wr_val[3:0];
      end
    end
  end

  // write channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_ix_r <= '0;
      w_data_r <= '0;
      w_strb_r <= '0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_have_r) begin
        aw_have_r <= 1'b1;
        aw_ix_r <= s_axi_awaddr[6:2];
      end
      if (s_axi_wvalid && !w_have_r) begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wr_map ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // read channel and sticky status, set beats the read clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
      sts_r <= '0;
      irq <= 1'b0;
    end else begin
      if (ar_take) begin
        rvalid_r <= 1'b1;
        rdata_r <= rd_word;
        rresp_r <= rd_map ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
      sts_r <= (rd_sts ? 4'h0 : sts_r) | sts_set;
      irq <= |(((rd_sts ? 4'h0 : sts_r) | sts_set) & mask_r);
    end
  end

  wire ms_end = div_r == $bits(div_r)'(MS_CYCLES - 1);
  // 1 ms tick and sample tick every SAMPLE_MS
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_r <= '0;
      ms_cnt_r <= '0;
      ms_tick_r <= 1'b0;
      smp_r <= 1'b0;
      smp_d_r <= 1'b0;
    end else begin
      ms_tick_r <= ms_end;
      div_r <= ms_end ? '0 : div_r + 1'b1;
      smp_r <= 1'b0;
      smp_d_r <= smp_r;
      if (ms_tick_r) begin
        smp_r <= ms_cnt_r == 7'(SAMPLE_MS - 1);
        ms_cnt_r <= ms_cnt_r == 7'(SAMPLE_MS - 1) ? '0 : ms_cnt_r + 7'h01;
      end
    end
  end

  // sampling, ratio, bias and heater fault counters
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pv_pre_r <= '0;
      rs_pre_r <= '0;
      pv_ctrl_r <= '0;
      cnt_lo_r <= '{8'h00, 8'h00};
      cnt_hi_r <= '{8'h00, 8'h00};
    end else if (smp_r) begin
      pv_pre_r <= scale(measured_value, cfg_r[OFF_PV_RATIO[6:2]],
                        cfg_r[OFF_PV_BIAS[6:2]]); // [RL6] [RL8]
      // same path serves cascade and ratio setting sources
      rs_pre_r <= scale(remote_setpoint, cfg_r[OFF_RS_RATIO[6:2]],
                        cfg_r[OFF_RS_BIAS[6:2]]); // [RL10] [RL12] [RL13]
      pv_ctrl_r <= ctrl[CB_SQRT] && 32'(pv_f) < cut_lvl ?
                   16'sh0000 : pv_f; // [RL9]
      for (int c = 0; c < 2; c++) begin
        if (type_b[c] && hsv[c] != 16'h0 && lo_hit[c]) begin // [RL3] [RL4]
          cnt_lo_r[c] <= lo_al[c] ? cnt_lo_r[c] : cnt_lo_r[c] + 8'h01;
        end else begin
          cnt_lo_r[c] <= 8'h00;
        end
        if (type_b[c] && hsv[c] != 16'h0 && hi_hit[c]) begin // [RL3] [RL5]
          cnt_hi_r[c] <= hi_al[c] ? cnt_hi_r[c] : cnt_hi_r[c] + 8'h01;
        end else begin
          cnt_hi_r[c] <= 8'h00;
        end
      end
    end
  end

  pic_lag #(.W(16), .TW(10)) u_pv_lag (
    .aclk(aclk),
    .aresetn(aresetn),
    .step(smp_d_r),
    .tau(cfg_r[OFF_PV_FILT[6:2]][9:0]), // [RL7]
    .din(pv_pre_r),
    .dout(pv_f)
  );

  pic_lag #(.W(16), .TW(10)) u_rs_lag (
    .aclk(aclk),
    .aresetn(aresetn),
    .step(smp_d_r),
    .tau(cfg_r[OFF_RS_FILT[6:2]][9:0]), // [RL11] [RL13]
    .din(rs_pre_r),
    .dout(rs_f)
  );

  pic_tprop #(.TW(10), .DW(10)) u_heat (
    .aclk(aclk),
    .aresetn(aresetn),
    .ms_tick(ms_tick_r),
    .enable(!ctrl[CB_HEAT_CONT]), // [RL16]
    .cycle_tenths(heat_cyc),
    .duty(manipulated_output_one), // [RL17]
    .out(heat_output)
  );

  pic_tprop #(.TW(10), .DW(10)) u_cool (
    .aclk(aclk),
    .aresetn(aresetn),
    .ms_tick(ms_tick_r),
    .enable(ctrl[CB_HEATCOOL] && !ctrl[CB_COOL_CONT]), // [RL15] [RL16]
    .cycle_tenths(cool_cyc),
    .duty(manipulated_output_two), // [RL17]
    .out(cool_output)
  );

  assign pv_out = pv_f;
  assign rs_out = rs_f;
  assign pv_ctrl_out = pv_ctrl_r;
  assign heater_fault_alarm_one = lo_al[0] | hi_al[0];
  assign heater_fault_alarm_two = lo_al[1] | hi_al[1];
endmodule : pic_top
`default_nettype wire

// file: pic_top_asserts.sv
// bus and output checks for the conditioning block
`default_nettype none
module pic_top_asserts
  import pic_pkg::*;
#(
  parameter int MS_CYCLES = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [pic_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [pic_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic heat_output,
  input wire logic cool_output,
  input wire logic heater_fault_alarm_one,
  input wire logic irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  chk_wr_answer: assert property (wr_both |-> ##1 !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer late or early");
  chk_ro_write: assert property ((wr_both ##0 s_axi_awaddr == OFF_STATUS)
    |-> ##2 s_axi_bresp == RESP_SLVERR) else $error("read-only write accepted");
  chk_rd_answer: assert property (rd_take |=> s_axi_rvalid)
    else $error("read answer missing");
  chk_rd_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
  chk_wr_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write resp moved");
  chk_rd_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("address taken while answering");
  chk_bad_addr: assert property ((rd_take ##0
    s_axi_araddr[6:2] > OFF_PV_CTRL[6:2])
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read answered okay");
  chk_reset_quiet: assert property ($rose(aresetn) |-> !heat_output &&
    !cool_output && !heater_fault_alarm_one && !irq)
    else $error("outputs active after reset");
  chk_alarm_steady: assert property ($rose(heater_fault_alarm_one)
    |=> heater_fault_alarm_one [*8]) else $error("alarm not per sample");
endmodule : pic_top_asserts
bind pic_top pic_top_asserts #(.MS_CYCLES(MS_CYCLES)) u_chk (.*);
`default_nettype wire

// file: pic_top_tb.sv
// self-checking bench for the process input conditioning block
`default_nettype none
module pic_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pic_pkg::*;
  localparam int MSC = 4;
  localparam int SMP = 100 * MSC;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [6:0] s_axi_awaddr = 7'h00, s_axi_araddr = 7'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [9:0] manipulated_output_one = 10'h0, manipulated_output_two = 10'h0;
  logic signed [15:0] pv_set = 16'h0, rs_set = 16'h0;
  logic [15:0] ct_set = 16'h0;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire logic s_axi_rvalid, heat_output, cool_output, irq;
  wire logic heater_fault_alarm_one, heater_fault_alarm_two;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  wire logic signed [15:0] measured_value, remote_setpoint, pv_out, rs_out;
  wire logic signed [15:0] pv_ctrl_out;
  wire logic [15:0] current_sensor_input_one, current_sensor_input_two;
  int bad_count = 0, checked = 0, hi_h, hi_c;
  logic [31:0] rd_v;
  logic [1:0] resp;
  always #20 aclk = ~aclk;
  pic_top #(.MS_CYCLES(MSC)) u_dut (.*);
  pic_field u_field (.aclk(aclk), .aresetn(aresetn), .pv_set(pv_set),
    .rs_set(rs_set), .ct_set(ct_set), .measured_value(measured_value),
    .remote_setpoint(remote_setpoint),
    .current_sensor_input_one(current_sensor_input_one),
    .current_sensor_input_two(current_sensor_input_two));
  task automatic chk(input string what, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask : wr
  task automatic rd(input logic [6:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd_v = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask : rd
  task automatic rc(input string n, input logic [6:0] a, input logic [31:0] e);
    rd(a);
    chk(n, rd_v, e);
    chk(n, {30'h0, resp}, {30'h0, RESP_OKAY});
  endtask : rc
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc
  task automatic meas(input int n);
    hi_h = 0;
    hi_c = 0;
    repeat (n) begin
      @(posedge aclk);
      hi_h += int'(heat_output === 1'b1);
      hi_c += int'(cool_output === 1'b1);
    end
  endtask : meas
  // waits for the next filter step, bounded by two samples
  task automatic wchg();
    logic signed [15:0] o;
    int k;
    o = pv_out;
    k = 0;
    while (pv_out === o && k < 2 * SMP) begin
      @(posedge aclk);
      k++;
    end
  endtask : wchg
  task automatic finish_test();
    $display("counts: checked %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : finish_test
  initial begin
    repeat (90000) @(posedge aclk);
    bad_count++;
    $display("mismatch watchdog expected done seen timeout");
    finish_test();
  end
  initial begin
    cyc(20);
    aresetn <= 1'b1;
    cyc(1);
    for (int i = 0; i < NCFG; i++) begin
      rc("cfg_rst", 7'(i * 4), {16'h0, CFG_RST[i]});
    end
    rc("mask_rst", OFF_MASK, 32'h0);
    rd(7'h60);
    chk("bad_rdata", rd_v, 32'h0);
    chk("bad_rresp", {30'h0, resp}, {30'h0, RESP_SLVERR});
    wr(OFF_STATUS, 16'h0001);
    chk("ro_bresp", {30'h0, resp}, {30'h0, RESP_SLVERR});
    wr(OFF_PV_RATIO, 16'd9999);
    rc("pv_ratio_hi", OFF_PV_RATIO, 32'd1500);
    wr(OFF_RS_RATIO, 16'd0);
    rc("rs_ratio_lo", OFF_RS_RATIO, 32'd1);
    wr(OFF_BRK1, 16'd2000);
    rc("brk_hi", OFF_BRK1, 32'd1000);
    wr(OFF_MLT2, 16'hFFFF);
    rc("mlt_hi", OFF_MLT2, 32'd1000);
    $display("test registers done");
    wr(OFF_PV_RATIO, 16'd1500);
    wr(OFF_PV_BIAS, 16'hFE0C);
    wr(OFF_RS_RATIO, 16'd2000);
    wr(OFF_RS_BIAS, 16'd100);
    pv_set <= 16'sd2000;
    rs_set <= 16'sd1234;
    cyc(2 * SMP + 20);
    chk("pv_out", {16'h0, pv_out}, 32'h9C4);
    chk("rs_out", {16'h0, rs_out}, 32'hA08);
    rc("pv_out_reg", OFF_PV_OUT, 32'h9C4);
    rs_set <= -16'sd2000;
    cyc(2 * SMP + 20);
    rc("rs_out_reg", OFF_RS_OUT, 32'hFFFFF0C4);
    wr(OFF_CTRL, 16'h0001);
    wr(OFF_PV_CUT, 16'd2500);
    wr(OFF_PV_RATIO, 16'd1000);
    wr(OFF_PV_BIAS, 16'd0);
    pv_set <= 16'sd2400;
    cyc(2 * SMP + 20);
    chk("cut_below", {16'h0, pv_ctrl_out}, 32'h0);
    pv_set <= 16'sd2500;
    cyc(2 * SMP + 20);
    chk("cut_at", {16'h0, pv_ctrl_out}, 32'h9C4);
    wr(OFF_PV_FILT, 16'd1);
    pv_set <= 16'sd4500;
    wchg();
    chk("lag_one", {16'h0, pv_out}, 32'hDAC);
    wchg();
    chk("lag_two", {16'h0, pv_out}, 32'hFA0);
    wr(OFF_PV_FILT, 16'd0);
    $display("test conditioning done");
    wr(OFF_CTRL, 16'h0002);
    wr(OFF_HSV1, 16'd1000);
    wr(OFF_DELAY, 16'h0303);
    wr(OFF_MASK, 16'h0005);
    wr(OFF_BRK1, 16'd300);
    manipulated_output_one <= 10'd500;
    ct_set <= 16'd250;
    cyc(3 * SMP + 20);
    chk("no_alarm", {31'h0, heater_fault_alarm_one}, 32'h0);
    chk("irq_idle", {31'h0, irq}, 32'h0);
    ct_set <= 16'd200;
    cyc(790);
    chk("brk_early", {31'h0, heater_fault_alarm_one}, 32'h0);
    cyc(520);
    chk("brk_alarm", {30'h0, heater_fault_alarm_two, heater_fault_alarm_one},
      32'h1);
    chk("irq_brk", {31'h0, irq}, 32'h1);
    rc("st_brk", OFF_STATUS, 32'h1);
    ct_set <= 16'd800;
    cyc(1310);
    chk("mlt_alarm", {31'h0, heater_fault_alarm_one}, 32'h1);
    rd(OFF_STATUS);
    rc("st_mlt", OFF_STATUS, 32'h4);
    ct_set <= 16'd500;
    cyc(2 * SMP + 20);
    rd(OFF_STATUS);
    rc("st_clear", OFF_STATUS, 32'h0);
    chk("irq_clear", {31'h0, irq}, 32'h0);
    wr(OFF_CTRL, 16'h0000);
    ct_set <= 16'd150;
    cyc(1310);
    chk("type_a", {31'h0, heater_fault_alarm_one}, 32'h0);
    rc("st_type_a", OFF_STATUS, 32'h0);
    wr(OFF_CTRL, 16'h0002);
    wr(OFF_BRK1, 16'd0);
    cyc(1310);
    chk("brk_off", {31'h0, heater_fault_alarm_one}, 32'h0);
    wr(OFF_MLT1, 16'd0);
    ct_set <= 16'd900;
    cyc(1310);
    chk("mlt_off", {31'h0, heater_fault_alarm_one}, 32'h0);
    $display("test heater fault done");
    wr(OFF_CTRL, 16'h0080);
    wr(OFF_HEAT_CYC, 16'd10);
    wr(OFF_COOL_CYC, 16'd5);
    manipulated_output_one <= 10'd250;
    manipulated_output_two <= 10'd800;
    cyc(8000);
    meas(4000);
    chk("heat_on", 32'(hi_h), 32'd1000);
    chk("cool_on", 32'(hi_c), 32'd3200);
    wr(OFF_CTRL, 16'h0000);
    wr(OFF_HEAT_CYC, 16'd0);
    cyc(8000);
    meas(8000);
    chk("heat_dflt", 32'(hi_h), 32'd2000);
    chk("cool_solo", 32'(hi_c), 32'd0);
    wr(OFF_CTRL, 16'h00D0);
    cyc(100);
    meas(4000);
    chk("heat_cont", 32'(hi_h), 32'd0);
    chk("cool_cont", 32'(hi_c), 32'd0);
    $display("test cycle outputs done");
    finish_test();
  end
endmodule : pic_top_tb
`default_nettype wire

// file: pic_tprop.sv
// time-proportional output over a programmable cycle
`default_nettype none
module pic_tprop #(
  parameter int TW = 10,
  parameter int DW = 10
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ms_tick,
  input wire logic enable,
  input wire logic [TW-1:0] cycle_tenths,
  input wire logic [DW-1:0] duty,
  output logic out
);
  logic [TW+6:0] cnt_r;
  logic [TW+6:0] period;
  logic [TW+10:0] on_lhs;
  logic [TW+10:0] on_rhs;
  logic wrap;
  // period in ms; on while cnt*10 < duty(0.1 %)*cycle(0.1 s)
  assign period = (TW+7)'(cycle_tenths) * (TW+7)'(100);
  assign wrap = (cnt_r + (TW+7)'(1)) >= period;
  assign on_lhs = (TW+11)'(cnt_r) * (TW+11)'(10);
  assign on_rhs = (TW+11)'(duty) * (TW+11)'(cycle_tenths);
  always_ff @(posedge aclk) begin
    if (!aresetn || !enable) begin
      cnt_r <= '0;
      out <= 1'b0;
    end else if (ms_tick) begin
      cnt_r <= wrap ? '0 : cnt_r + (TW+7)'(1);
      out <= on_lhs < on_rhs;
    end
  end
endmodule : pic_tprop
`default_nettype wire
